// File: verilog/motion_dispatch_defs.vh
// How it works
// - port select 1..6, port 1 after reset
// - bad port number terminates execution
// - port select only in expansion mode
// - port select F loads high-speed rate
// - F field picks function zero to six
// - F outside zero to six terminates
// - functions 0-3 need valid X/Y axis
// - digit picks register, minus negates contents
// - function 1 waits for distance travelled
// - functions 3-5 need overlapped mode
// - unarmed registration blocks other motion commands
// - function 4 arms pending registration trigger
// - abort stops motion, never a home
// - home runs, captures, stops, re-references
// - trap line 0..400, zero disables trapping
// - bad trap line terminates execution
// - limit jumps to trap line, clears loops
// - trap command takes optional feed rate
// - overlapped mode lets non-motion lines run
`ifndef MOTION_DISPATCH_DEFS_VH
`define MOTION_DISPATCH_DEFS_VH
`define APB_CTRL        12'h000
`define APB_CMD         12'h004
`define APB_ARG         12'h008
`define APB_FEED        12'h00c
`define APB_STATUS      12'h010
`define APB_PORT        12'h014
`define APB_TRAP        12'h018
`define APB_RATE        12'h01c
`define APB_POS         12'h020
`define APB_REGSEL      12'h024
`define APB_REGDATA     12'h028
`define APB_TARGET      12'h02c
`define APB_HOMEPOS     12'h030
`define OP_PORT_SEL     2'h0
`define OP_REG_EXEC     2'h1
`define OP_ERR_TRAP     2'h2
`define PORT_RESET      3'h1
`define PORT_MAX        3'h6
`define TRAP_MAX        9'h190
`define FEED_MAX        20'hf423f
`define FN_MAX          3'h6
`define REG_MAX         4'h9
`define EXP_MODE_IO     4'h2
`define STEP_DIV        16'h0028
`endif

// File: verilog/axis_stepper.v
`include "motion_dispatch_defs.vh"
module axis_stepper
(
    // clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // control
    input  wire        start,
    input  wire        homeStart,
    input  wire        stopReq,
    input  wire [31:0] distance,
    input  wire        homeDir,
    input  wire        homeSwitch,
    // status
    output reg         busy,
    output reg         homing,
    output reg         stepPulse,
    output reg         stepDir,
    output reg  [31:0] travelled,
    output reg  [31:0] position,
    output reg  [31:0] homeCapture
);
    reg [15:0] divCount;
    reg [31:0] remaining;
    wire       tick = (divCount == `STEP_DIV);

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divCount    <= 16'h0000;
            busy        <= 1'b0;
            homing      <= 1'b0;
            stepPulse   <= 1'b0;
            stepDir     <= 1'b0;
            travelled   <= 32'h00000000;
            position    <= 32'h00000000;
            homeCapture <= 32'h00000000;
            remaining   <= 32'h00000000;
        end
        else
        begin
            divCount  <= tick ? 16'h0000 : divCount + 16'h0001;
            stepPulse <= 1'b0;
            if (homeStart && !busy)
            begin
                busy      <= 1'b1;
                homing    <= 1'b1;
                stepDir   <= homeDir;
                travelled <= 32'h00000000;
            end
            else if (start && !busy)
            begin
                busy      <= (distance != 32'h00000000);
                stepDir   <= distance[31];
                remaining <= distance[31] ? (32'h00000000 - distance) : distance;
                travelled <= 32'h00000000;
            end
            else if (homing && homeSwitch)
            begin
                // capture then zero at the switch
                homeCapture <= position;
                position    <= 32'h00000000;
                busy        <= 1'b0;
                homing      <= 1'b0;
            end
            else if (stopReq && busy && !homing)
            begin
                busy <= 1'b0;
            end
            else if (busy && tick)
            begin
                stepPulse <= 1'b1;
                travelled <= travelled + 32'h00000001;
                position  <= stepDir ? position - 32'h00000001 : position + 32'h00000001;
                if (!homing)
                begin
                    remaining <= remaining - 32'h00000001;
                    if (remaining == 32'h00000001)
                        busy <= 1'b0;
                end
            end
        end
    end
endmodule // axis_stepper

// File: verilog/register_motion_dispatch.v
`include "motion_dispatch_defs.vh"
module register_motion_dispatch
(
    // clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // field pins
    input  wire        homeSwitchX,
    input  wire        homeSwitchY,
    input  wire        limitIn,
    // motor drive and status
    output reg         stepX,
    output reg         dirX,
    output reg         stepY,
    output reg         dirY,
    output reg  [2:0]  expansionPort,
    output reg         errorStatus,
    output reg         trapTaken
);
    localparam IDLE = 2'h0;
    localparam WAIT = 2'h1;
    localparam HALT = 2'h2;

    reg [1:0]  state;
    reg        overlapMode;
    reg [3:0]  expansionConfig;
    reg        homeDirection;
    reg [1:0]  cmdOp;
    reg        hasX;
    reg        hasY;
    reg        hasF;
    reg        negSign;
    reg [3:0]  fieldDigit;
    reg [8:0]  lineField;
    reg [19:0] feedField;
    reg [19:0] highSpeedRate;
    reg [19:0] feedRate;
    reg [8:0]  trapLine;
    reg [8:0]  programLine;
    reg        loopsCleared;
    reg        regPending;
    reg        trigArmed;
    reg        axisSel;
    reg [31:0] waitTarget;
    reg [3:0]  regSel;
    reg [31:0] workReg [0:9];
    reg        startX;
    reg        startY;
    reg        homeGoX;
    reg        homeGoY;
    reg        abortReq;
    reg [31:0] moveDist;
    reg        hsX1;
    reg        hsX2;
    reg        hsY1;
    reg        hsY2;
    reg        lim1;
    reg        lim2;
    reg        limPrev;

    wire        busyX;
    wire        busyY;
    wire        homingX;
    wire        homingY;
    wire        pulseX;
    wire        pulseY;
    wire        dX;
    wire        dY;
    wire [31:0] travX;
    wire [31:0] travY;
    wire [31:0] posX;
    wire [31:0] posY;
    wire [31:0] capX;
    wire [31:0] capY;

    wire access = psel && penable;
    wire wr     = access && pwrite;
    wire goCmd  = wr && (paddr == `APB_CMD) && pwdata[0];
    wire motionBusy = busyX || busyY;
    wire [31:0] regVal = workReg[fieldDigit];
    wire [31:0] signedReg = negSign ? (32'h00000000 - regVal) : regVal;
    wire [2:0]  fn = feedField[2:0];
    wire limitEdge = lim2 && !limPrev;
    wire [31:0] travActive = axisSel ? travY : travX;

    axis_stepper axisX
    (
        .clock       (clock),
        .arst_n      (arst_n),
        .start       (startX),
        .homeStart   (homeGoX),
        .stopReq     (abortReq),
        .distance    (moveDist),
        .homeDir     (homeDirection),
        .homeSwitch  (hsX2),
        .busy        (busyX),
        .homing      (homingX),
        .stepPulse   (pulseX),
        .stepDir     (dX),
        .travelled   (travX),
        .position    (posX),
        .homeCapture (capX)
    );

    axis_stepper axisY
    (
        .clock       (clock),
        .arst_n      (arst_n),
        .start       (startY),
        .homeStart   (homeGoY),
        .stopReq     (abortReq),
        .distance    (moveDist),
        .homeDir     (homeDirection),
        .homeSwitch  (hsY2),
        .busy        (busyY),
        .homing      (homingY),
        .stepPulse   (pulseY),
        .stepDir     (dY),
        .travelled   (travY),
        .position    (posY),
        .homeCapture (capY)
    );

    // pins are asynchronous to clock
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hsX1    <= 1'b0;
            hsX2    <= 1'b0;
            hsY1    <= 1'b0;
            hsY2    <= 1'b0;
            lim1    <= 1'b0;
            lim2    <= 1'b0;
            limPrev <= 1'b0;
            stepX   <= 1'b0;
            dirX    <= 1'b0;
            stepY   <= 1'b0;
            dirY    <= 1'b0;
        end
        else
        begin
            hsX1    <= homeSwitchX;
            hsX2    <= hsX1;
            hsY1    <= homeSwitchY;
            hsY2    <= hsY1;
            lim1    <= limitIn;
            lim2    <= lim1;
            limPrev <= lim2;
            stepX   <= pulseX;
            dirX    <= dX;
            stepY   <= pulseY;
            dirY    <= dY;
        end
    end

    // register file: written from apb in any sequencer state
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1)
        begin : regs
            always @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    workReg[gi] <= 32'h00000000;
                else if (wr && paddr == `APB_REGDATA && regSel == gi)
                    workReg[gi] <= pwdata;
            end
        end
    endgenerate

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state           <= IDLE;
            overlapMode     <= 1'b0;
            expansionConfig <= 4'h0;
            homeDirection   <= 1'b0;
            cmdOp           <= 2'h0;
            hasX            <= 1'b0;
            hasY            <= 1'b0;
            hasF            <= 1'b0;
            negSign         <= 1'b0;
            fieldDigit      <= 4'h0;
            lineField       <= 9'h000;
            feedField       <= 20'h00000;
            highSpeedRate   <= 20'h00000;
            feedRate        <= 20'h00000;
            trapLine        <= 9'h000;
            programLine     <= 9'h000;
            loopsCleared    <= 1'b0;
            regPending      <= 1'b0;
            trigArmed       <= 1'b0;
            axisSel         <= 1'b0;
            waitTarget      <= 32'h00000000;
            regSel          <= 4'h0;
            startX          <= 1'b0;
            startY          <= 1'b0;
            homeGoX         <= 1'b0;
            homeGoY         <= 1'b0;
            abortReq        <= 1'b0;
            moveDist        <= 32'h00000000;
            expansionPort   <= `PORT_RESET;
            errorStatus     <= 1'b0;
            trapTaken       <= 1'b0;
        end
        else
        begin
            startX   <= 1'b0;
            startY   <= 1'b0;
            homeGoX  <= 1'b0;
            homeGoY  <= 1'b0;
            abortReq <= 1'b0;
            loopsCleared <= 1'b0;
            if (wr && paddr == `APB_CTRL)
            begin
                overlapMode     <= pwdata[0];
                homeDirection   <= pwdata[1];
                expansionConfig <= pwdata[7:4];
                if (pwdata[8])
                begin
                    // restart clears a halted sequencer
                    state       <= IDLE;
                    errorStatus <= 1'b0;
                end
            end
            if (wr && paddr == `APB_ARG)
            begin
                cmdOp      <= pwdata[1:0];
                hasX       <= pwdata[2];
                hasY       <= pwdata[3];
                hasF       <= pwdata[4];
                negSign    <= pwdata[5];
                fieldDigit <= pwdata[11:8];
                lineField  <= pwdata[24:16];
            end
            if (wr && paddr == `APB_FEED)
                feedField <= pwdata[19:0];
            if (wr && paddr == `APB_REGSEL)
                regSel <= pwdata[3:0];
            if (wr && paddr == `APB_STATUS && pwdata[1])
                trapTaken <= 1'b0;
            if (regPending && trigArmed && !motionBusy)
                regPending <= 1'b0;
            // limit event outranks an execution step
            if (limitEdge && state != HALT)
            begin
                if (trapLine != 9'h000)
                begin
                    programLine  <= trapLine;
                    loopsCleared <= 1'b1;
                    trapTaken    <= 1'b1;
                    state        <= IDLE;
                end
                else
                begin
                    state       <= HALT;
                    errorStatus <= 1'b1;
                end
            end
            else
            case (state)
                IDLE:
                begin
                    if (goCmd)
                    begin
                        case (cmdOp)
                            `OP_PORT_SEL:
                            begin
                                if (expansionConfig == `EXP_MODE_IO)
                                begin
                                    if (!(hasX || hasY) || fieldDigit == 4'h0
                                        || fieldDigit > {1'b0, `PORT_MAX})
                                    begin
                                        state       <= HALT;
                                        errorStatus <= 1'b1;
                                    end
                                    else
                                    begin
                                        expansionPort <= fieldDigit[2:0];
                                        if (hasF)
                                            highSpeedRate <= feedField;
                                    end
                                end
                            end
                            `OP_REG_EXEC:
                            begin
                                if (!hasF || feedField > {17'h00000, `FN_MAX})
                                begin
                                    state       <= HALT;
                                    errorStatus <= 1'b1;
                                end
                                else if (fn >= 3'h3 && fn <= 3'h5 && !overlapMode)
                                begin
                                    state       <= HALT;
                                    errorStatus <= 1'b1;
                                end
                                else if (regPending && !trigArmed && fn != 3'h4)
                                begin
                                    state       <= HALT;
                                    errorStatus <= 1'b1;
                                end
                                else if (fn <= 3'h3 && (!(hasX ^ hasY)
                                         || fieldDigit == 4'h0 || fieldDigit > `REG_MAX))
                                begin
                                    state       <= HALT;
                                    errorStatus <= 1'b1;
                                end
                                else
                                begin
                                    case (fn)
                                        3'h0, 3'h2, 3'h3:
                                        begin
                                            axisSel  <= hasY;
                                            moveDist <= signedReg;
                                            startX   <= hasX;
                                            startY   <= hasY;
                                            regPending <= (fn == 3'h3) || (fn == 3'h2);
                                            trigArmed  <= (fn == 3'h2);
                                            waitTarget <= 32'hffffffff;
                                            // without overlap the line waits for motion
                                            if (!overlapMode)
                                                state <= WAIT;
                                        end
                                        3'h1:
                                        begin
                                            axisSel    <= hasY;
                                            waitTarget <= signedReg[31] ?
                                                (32'h00000000 - signedReg) : signedReg;
                                            state      <= WAIT;
                                        end
                                        3'h4:
                                            trigArmed <= regPending;
                                        3'h5:
                                        begin
                                            abortReq   <= 1'b1;
                                            regPending <= 1'b0;
                                        end
                                        default:
                                        begin
                                            homeGoX <= hasX || !hasY;
                                            homeGoY <= hasY;
                                        end
                                    endcase
                                end
                            end
                            `OP_ERR_TRAP:
                            begin
                                if (!(hasX || hasY) || lineField > `TRAP_MAX
                                    || (hasF && feedField > `FEED_MAX))
                                begin
                                    state       <= HALT;
                                    errorStatus <= 1'b1;
                                end
                                else
                                begin
                                    trapLine <= lineField;
                                    if (hasF)
                                        feedRate <= feedField;
                                end
                            end
                            default:
                            begin
                                state       <= HALT;
                                errorStatus <= 1'b1;
                            end
                        endcase
                    end
                end
                WAIT:
                begin
                    // a stopped axis cannot reach the target, so stop waiting
                    // busy rises a cycle after start, so skip that cycle
                    if (!startX && !startY && (travActive >= waitTarget || !motionBusy))
                        state <= IDLE;
                end
                default:
                    // restart must outrank the held error
                    if (!(wr && paddr == `APB_CTRL && pwdata[8]))
                        errorStatus <= 1'b1;
            endcase
        end
    end

    // apb: zero wait states, unmapped reads zero with pslverr
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable)
            begin
                if (paddr == `APB_CTRL)
                    prdata <= {24'h000000, expansionConfig, 2'h0, homeDirection, overlapMode};
                else if (paddr == `APB_ARG)
                    prdata <= {7'h00, lineField, 4'h0, fieldDigit, 2'h0, negSign, hasF,
                               hasY, hasX, cmdOp};
                else if (paddr == `APB_FEED)
                    prdata <= {12'h000, feedField};
                else if (paddr == `APB_STATUS)
                    prdata <= {22'h000000, loopsCleared, trigArmed, regPending,
                               homingY | homingX, busyY, busyX, state, trapTaken,
                               errorStatus};
                else if (paddr == `APB_PORT)
                    prdata <= {29'h00000000, expansionPort};
                else if (paddr == `APB_TRAP)
                    prdata <= {23'h000000, trapLine};
                else if (paddr == `APB_RATE)
                    prdata <= {feedRate[11:0], highSpeedRate};
                else if (paddr == `APB_POS)
                    prdata <= axisSel ? posY : posX;
                else if (paddr == `APB_REGSEL)
                    prdata <= {28'h0000000, regSel};
                else if (paddr == `APB_REGDATA)
                    prdata <= (regSel > `REG_MAX) ? 32'h00000000 : workReg[regSel];
                else if (paddr == `APB_TARGET)
                    prdata <= {23'h000000, programLine};
                else if (paddr == `APB_HOMEPOS)
                    prdata <= axisSel ? capY : capX;
                else
                    pslverr <= 1'b1;
            end
        end
    end
endmodule // register_motion_dispatch

// File: verif/register_motion_dispatch_props.sv
`include "motion_dispatch_defs.vh"
module register_motion_dispatch_props
(
    // clock and reset
    input wire logic       clock,
    input wire logic       arst_n,
    // apb
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    // outputs watched
    input wire logic       stepX,
    input wire logic       stepY,
    input wire logic [2:0] expansionPort,
    input wire logic       errorStatus,
    input wire logic       trapTaken
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_port_range: assert property (expansionPort >= 3'h1 && expansionPort <= `PORT_MAX)
        else $error("expansion port out of range");
    a_error_sticky: assert property (errorStatus && !(psel && pwrite) |=> errorStatus)
        else $error("error status dropped without a write");
    a_trap_sticky: assert property (trapTaken && !(psel && pwrite) |=> trapTaken)
        else $error("trap flag dropped without a write");
    a_stepx_pulse: assert property (stepX |=> !stepX [*8])
        else $error("x steps too close");
    a_stepy_pulse: assert property (stepY |=> !stepY [*8])
        else $error("y steps too close");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
endmodule // register_motion_dispatch_props
bind register_motion_dispatch register_motion_dispatch_props props_u (.*);

// File: verif/drive_model.sv
module drive_model
(
    input wire logic        clock,
    input wire logic        stepX,
    input wire logic        homeArm,
    output logic            homeSwitchX,
    output logic            homeSwitchY,
    output logic     [31:0] stepsX
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] armedAt = 32'h0;
    initial stepsX = 32'h0;
    always @(posedge clock)
    begin
        if (stepX)
            stepsX <= stepsX + 32'h1;
        if (!homeArm)
            armedAt <= stepsX;
    end
    // switch closes three steps into a home run, y switch stays open
    assign homeSwitchX = homeArm && (stepsX - armedAt >= 32'h3);
    assign homeSwitchY = 1'b0;
endmodule // drive_model

// File: verif/register_motion_dispatch_bench.sv
`include "motion_dispatch_defs.vh"
module register_motion_dispatch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        limitIn = 0, homeArm = 0, pready, pslverr, homeSwitchX, homeSwitchY;
    logic        stepX, dirX, stepY, dirY, errorStatus, trapTaken;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, st, base, stepsX;
    logic [2:0]  expansionPort;
    int          errors = 0, samples_checked = 0, cycles = 0;
    always #12.5 clock = ~clock;
    register_motion_dispatch dut_u (.*);
    drive_model model_u (.clock(clock), .stepX(stepX), .homeArm(homeArm),
        .homeSwitchX(homeSwitchX), .homeSwitchY(homeSwitchY), .stepsX(stepsX));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic exec(input logic [31:0] arg, input logic [31:0] f);
        apb(1'b1, `APB_ARG, arg);
        apb(1'b1, `APB_FEED, f);
        apb(1'b1, `APB_CMD, 32'h1);
        repeat (8) @(posedge clock);
    endtask
    // command that must end in termination; status kept, then restart
    task automatic fault(input logic [31:0] arg, input logic [31:0] f);
        exec(arg, f);
        apb(1'b0, `APB_STATUS, 32'h0);
        st = rd;
        check(errorStatus, 1'b1);
        apb(1'b1, `APB_CTRL, 32'h120);
        apb(1'b1, `APB_CTRL, 32'h20);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, `APB_PORT, 32'h0);
        check(rd[2:0], 3'h1);
        apb(1'b1, `APB_CTRL, 32'h20);
        exec(32'h0614, 32'h64);
        check(expansionPort, 3'h6);
        fault(32'h0704, 32'h0);
        check(st[0], 1'b1);
        apb(1'b1, `APB_CTRL, 32'h0);
        exec(32'h0304, 32'h0);
        check(expansionPort, 3'h6);
        $display("port select done");
        fault(32'h0215, 32'h7);
        check(st[0], 1'b1);
        fault(32'h0011, 32'h0);
        check(st[0], 1'b1);
        fault(32'h0215, 32'h3);
        check(st[0], 1'b1);
        $display("faulty commands done");
        apb(1'b1, `APB_REGSEL, 32'h2);
        apb(1'b1, `APB_REGDATA, 32'h5);
        base = stepsX;
        exec(32'h0215, 32'h0);
        repeat (400) @(posedge clock);
        check(stepsX - base, 32'h5);
        check(dirX, 1'b0);
        exec(32'h0235, 32'h0);
        repeat (400) @(posedge clock);
        check(stepsX - base, 32'ha);
        check(dirX, 1'b1);
        homeArm <= 1'b1;
        exec(32'h0015, 32'h6);
        repeat (600) @(posedge clock);
        apb(1'b0, `APB_STATUS, 32'h0);
        check(rd[6], 1'b0);
        apb(1'b0, `APB_HOMEPOS, 32'h0);
        check(rd, 32'h3);
        homeArm <= 1'b0;
        $display("motion done");
        apb(1'b1, `APB_CTRL, 32'h21);
        exec(32'h0219, 32'h3);
        fault(32'h0215, 32'h0);
        check(st[0], 1'b1);
        apb(1'b1, `APB_CTRL, 32'h21);
        exec(32'h0011, 32'h4);
        apb(1'b0, `APB_STATUS, 32'h0);
        check(rd[8], 1'b1);
        repeat (300) @(posedge clock);
        apb(1'b0, `APB_POS, 32'h0);
        check(rd, 32'h5);
        check(dirY, 1'b0);
        exec(32'h0215, 32'h0);
        exec(32'h0215, 32'h1);
        apb(1'b0, `APB_STATUS, 32'h0);
        check(rd[3:2], 2'h1);
        repeat (300) @(posedge clock);
        exec(32'h0215, 32'h0);
        exec(32'h0011, 32'h5);
        apb(1'b0, `APB_STATUS, 32'h0);
        check(rd[5:2], 4'h0);
        $display("overlap done");
        fault(32'h01f40006, 32'h0);
        check(st[0], 1'b1);
        exec(32'h000a0016, 32'h7b);
        limitIn <= 1'b1;
        repeat (10) @(posedge clock);
        limitIn <= 1'b0;
        repeat (10) @(posedge clock);
        check(trapTaken, 1'b1);
        check(errorStatus, 1'b0);
        apb(1'b0, `APB_TARGET, 32'h0);
        check(rd[8:0], 9'h00a);
        apb(1'b0, `APB_RATE, 32'h0);
        check(rd[31:20], 12'h07b);
        check(rd[19:0], 20'h00064);
        exec(32'h00000006, 32'h0);
        limitIn <= 1'b1;
        repeat (10) @(posedge clock);
        check(errorStatus, 1'b1);
        $display("trap done");
        end_of_test();
    end
endmodule // register_motion_dispatch_bench
